// ===== rtl/rph_rx_packet_handler.sv
// Purpose: Receive packet handler: preamble, sync, Manchester, CRC, FIFO
// Assumes: rx_line is the demodulated level, synchronous to clk
// Notes: Outputs of the top are registered; FIFO has a registered head
`timescale 1ns/100ps

module rph_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr, rd_ptr;
  logic [AW:0] count;
  logic do_wr, do_rd;

  assign in_ready = (count != (AW+1)'(D));
  assign do_wr = in_valid && in_ready;
  assign do_rd = (count != '0) && (!out_valid || out_ready);

  always_ff @(posedge clk)
  begin
    if (do_wr)
      mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_rd)
        rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  // Head register keeps the host port flop-driven
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else if (do_rd)
    begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr];
    end
    else if (out_ready)
      out_valid <= 1'b0;
  end
endmodule : rph_fifo

module rph_rx_packet_handler
  import rph_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Demodulated stream
  input wire logic rx_line,
  input wire logic rx_enable,
  // Configuration
  input wire logic [15:0] rate_div,
  input wire logic ook_mode,
  input wire logic [7:0] preamble_len,
  input wire logic skip_preamble,
  input wire logic [1:0] sync_len,
  input wire logic [31:0] sync_word,
  input wire logic manchester_en,
  input wire logic crc_en,
  input wire logic [7:0] payload_len,
  // Host side
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  // Events and status
  output logic pkt_valid,
  output logic pkt_error,
  output logic sync_found,
  output logic rate_error,
  output logic busy
);
  rph_state_t state;
  logic [15:0] div_eff, chip_div, tick_cnt;
  logic tick, have_half, half, bit_stb, bit_val;
  logic [7:0] pre_bytes, to_cnt, byte_cnt, byte_sr, push_data;
  logic [10:0] alt_cnt;
  logic [31:0] shreg, next_shift, sync_eff, sync_mask;
  logic [1:0] sync_len_eff;
  logic [3:0] sync_byte_ok;
  logic sync_hit, push_valid, push_ready, ovf;
  logic [2:0] bit_cnt;
  logic [3:0] crc_bits;
  logic [15:0] crc, rx_crc, next_crc;

  // ****************************************
  // Rate and configuration
  // ****************************************
  always_comb
  begin
    div_eff = rate_div;
    if (ook_mode)
    begin
      if (rate_div < DIV_OOK_MIN)
        div_eff = DIV_OOK_MIN;
      else if (rate_div > DIV_OOK_MAX)
        div_eff = DIV_OOK_MAX;
    end
    else if (rate_div < DIV_FSK_MIN)
      div_eff = DIV_FSK_MIN;
    else if (rate_div > DIV_FSK_MAX)
      div_eff = DIV_FSK_MAX;
  end

  // Manchester sends two chips per bit
  assign chip_div = manchester_en ? {1'b0, div_eff[15:1]} : div_eff;
  assign pre_bytes = (preamble_len == 8'h00) ? PRE_DEF :
                     (preamble_len < PRE_MIN) ? PRE_MIN : preamble_len;
  assign sync_eff = (sync_word == 32'h0) ? SYNC_DEF : sync_word;
  assign sync_len_eff = (sync_word == 32'h0) ? SYNC_DEF_LEN : sync_len;
  assign next_shift = {shreg[30:0], bit_val};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      assign sync_mask[gi*8 +: 8] = (2'(gi) <= sync_len_eff) ? 8'hff : 8'h00;
      assign sync_byte_ok[gi] = ((next_shift[gi*8 +: 8] ^ sync_eff[gi*8 +: 8])
                                 & sync_mask[gi*8 +: 8]) == 8'h00;
    end
  endgenerate
  assign sync_hit = &sync_byte_ok;

  // CRC bit step, MSB first
  assign next_crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ bit_val) ? CRC_POLY : 16'h0000);

  always_ff @(posedge clk)
  begin
    if (rst)
      rate_error <= 1'b0;
    else
      rate_error <= (div_eff != rate_div);
  end

  // ****************************************
  // Chip sampling and Manchester decode
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst || !rx_enable)
    begin
      tick_cnt <= 16'h0000;
      tick <= 1'b0;
    end
    else if (tick_cnt >= chip_div - 16'h0001)
    begin
      tick_cnt <= 16'h0000;
      tick <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || !rx_enable)
    begin
      have_half <= 1'b0;
      half <= 1'b0;
      bit_stb <= 1'b0;
      bit_val <= 1'b0;
    end
    else
    begin
      bit_stb <= 1'b0;
      if (tick && !manchester_en)
      begin
        bit_stb <= 1'b1;
        bit_val <= rx_line;
      end
      else if (tick && !have_half)
      begin
        have_half <= 1'b1;
        half <= rx_line;
      end
      else if (tick && rx_line != half)
      begin
        bit_stb <= 1'b1;
        bit_val <= half;
        have_half <= 1'b0;
      end
      else if (tick)
        half <= rx_line; // No transition: slip one chip to regain alignment
    end
  end

  // ****************************************
  // Framing state machine
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst || !rx_enable)
    begin
      state <= ST_IDLE;
      shreg <= 32'h0;
      alt_cnt <= 11'h000;
      to_cnt <= 8'h00;
      bit_cnt <= 3'h0;
      byte_cnt <= 8'h00;
      byte_sr <= 8'h00;
      crc <= CRC_SEED;
      rx_crc <= 16'h0000;
      crc_bits <= 4'h0;
      sync_found <= 1'b0;
      pkt_valid <= 1'b0;
      pkt_error <= 1'b0;
      push_valid <= 1'b0;
      push_data <= 8'h00;
      ovf <= 1'b0;
    end
    else
    begin
      sync_found <= 1'b0;
      pkt_valid <= 1'b0;
      pkt_error <= 1'b0;
      push_valid <= 1'b0;
      if (push_valid && !push_ready)
        ovf <= 1'b1; // Radio cannot stall; a lost byte spoils the packet when crc_en is set
      if (bit_stb)
      begin
        shreg <= next_shift;
        case (state)
          ST_IDLE:
          begin
            // Alternating run must open with a zero, as in 55h
            if (alt_cnt != 11'h000 && bit_val != shreg[0] && alt_cnt != 11'h7ff)
              alt_cnt <= alt_cnt + 11'h001;
            else if (alt_cnt == 11'h000 || bit_val == shreg[0])
              alt_cnt <= bit_val ? 11'h000 : 11'h001;
            if (skip_preamble && sync_hit)
            begin
              state <= ST_DATA;
              sync_found <= 1'b1;
              // Counters restart here too; a packet may follow without a disable
              bit_cnt <= 3'h0;
              byte_cnt <= 8'h00;
              crc <= CRC_SEED;
              ovf <= 1'b0;
            end
            else if (!skip_preamble && alt_cnt + 11'h001 >= {pre_bytes, 3'b000}
                     && bit_val != shreg[0])
            begin
              state <= ST_SYNC;
              to_cnt <= 8'h00;
            end
          end
          ST_SYNC:
          begin
            to_cnt <= to_cnt + 8'h01;
            if (sync_hit)
            begin
              state <= ST_DATA;
              sync_found <= 1'b1;
              bit_cnt <= 3'h0;
              byte_cnt <= 8'h00;
              crc <= CRC_SEED;
              ovf <= 1'b0;
            end
            else if (to_cnt == SYNC_TIMEOUT)
            begin
              state <= ST_IDLE;
              alt_cnt <= 11'h000;
            end
          end
          ST_DATA:
          begin
            byte_sr <= {byte_sr[6:0], bit_val};
            crc <= next_crc;
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7)
            begin
              push_valid <= 1'b1;
              push_data <= {byte_sr[6:0], bit_val};
              byte_cnt <= byte_cnt + 8'h01;
              if (byte_cnt == payload_len - 8'h01)
              begin
                crc_bits <= 4'h0;
                if (crc_en)
                  state <= ST_CRC;
                else
                begin
                  state <= ST_IDLE;
                  alt_cnt <= 11'h000;
                  pkt_valid <= 1'b1;
                end
              end
            end
          end
          ST_CRC:
          begin
            rx_crc <= {rx_crc[14:0], bit_val};
            crc_bits <= crc_bits + 4'h1;
            if (crc_bits == 4'hf)
            begin
              state <= ST_IDLE;
              alt_cnt <= 11'h000;
              if (crc == {rx_crc[14:0], bit_val} && !ovf)
                pkt_valid <= 1'b1;
              else
                pkt_error <= 1'b1;
            end
          end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      busy <= 1'b0;
    else
      busy <= (state != ST_IDLE);
  end

  // ****************************************
  // Receive FIFO
  // ****************************************
  rph_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_crc_end;
    rx_enable && state == ST_CRC && bit_stb && crc_bits == 4'hf;
  endsequence

  sequence s_sync_hit_idle;
    rx_enable && state == ST_IDLE && skip_preamble && bit_stb && sync_hit;
  endsequence

  chk_outcome_one: assert property (s_crc_end |=> (pkt_valid ^ pkt_error))
    else $error("CRC end without exactly one outcome");
  chk_no_both: assert property (!(pkt_valid && pkt_error))
    else $error("Valid and error raised together");
  chk_valid_after_crc: assert property (pkt_valid && crc_en |-> $past(state) == ST_CRC)
    else $error("Valid packet without CRC phase");
  chk_seed_at_data: assert property ($rose(state == ST_DATA) |-> crc == CRC_SEED)
    else $error("CRC not seeded at payload start");
  chk_sync_to_data: assert property (sync_found |-> state == ST_DATA)
    else $error("Sync reported outside payload");
  chk_skip_pre: assert property (s_sync_hit_idle |=> state == ST_DATA && sync_found)
    else $error("Sync alone did not start payload");
  chk_pre_default: assert property (preamble_len == 8'h00 |-> pre_bytes == PRE_DEF)
    else $error("Default preamble length wrong");
  chk_sync_default: assert property (sync_word == 32'h0 |-> sync_mask == 32'h0000_ffff)
    else $error("Default sync length wrong");
  chk_rate_ook: assert property (ook_mode && rate_div < DIV_OOK_MIN |=> rate_error)
    else $error("OOK rate over limit not flagged");
  chk_manch_slip: assert property (rx_enable && manchester_en && tick && have_half
                                   && rx_line == half |=> !bit_stb)
    else $error("Manchester bit without transition");
endmodule : rph_rx_packet_handler

// ===== rtl/rph_pkg.sv
// Purpose: Shared constants for the receive packet handler
// Assumes: 20 MHz modem clock, bits arrive MSB first
// Notes: Configuration arrives as plain ports, no register bus
package rph_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int FSK_MIN_BPS = 1_000;
  localparam int FSK_MAX_BPS = 500_000;
  localparam int OOK_MIN_BPS = 500;
  localparam int OOK_MAX_BPS = 120_000;
  // Clocks per bit; shortest bit rounds up, longest rounds down
  localparam logic [15:0] DIV_FSK_MIN = 16'((CLK_HZ + FSK_MAX_BPS - 1) / FSK_MAX_BPS);
  localparam logic [15:0] DIV_FSK_MAX = 16'(CLK_HZ / FSK_MIN_BPS);
  localparam logic [15:0] DIV_OOK_MIN = 16'((CLK_HZ + OOK_MAX_BPS - 1) / OOK_MAX_BPS);
  localparam logic [15:0] DIV_OOK_MAX = 16'(CLK_HZ / OOK_MIN_BPS);
  localparam logic [7:0] PRE_BYTE = 8'h55;
  localparam logic [7:0] PRE_MIN = 8'h03;
  localparam logic [7:0] PRE_DEF = 8'h04;
  localparam logic [31:0] SYNC_DEF = 32'h0000_2dd4;
  localparam logic [1:0] SYNC_DEF_LEN = 2'h1;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_SEED = 16'hffff;
  localparam logic [7:0] SYNC_TIMEOUT = 8'h40;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 16;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SYNC = 2'b01,
    ST_DATA = 2'b10,
    ST_CRC  = 2'b11
  } rph_state_t;
endpackage : rph_pkg

// ===== testbench/rph_tx_model.sv
// Purpose: Remote transmitter model driving framed packets on rx_line
// Assumes: Bits and chips change on the falling clock edge
// Notes: Line shows the inverse of the last chip between frames
`timescale 1ns/100ps

module rph_tx_model
(
  // Line
  input wire logic clk,
  output logic rx_line
);
  logic [15:0] crc;

  initial rx_line = 1'b1;

  task automatic chip_out(input logic v, input int n);
    rx_line = v;
    repeat (n) @(negedge clk);
  endtask : chip_out

  // Manchester: pair 10 is a one, 01 a zero
  task automatic byte_out(input logic [7:0] v, input int div, input bit man);
    for (int i = 7; i >= 0; i--)
    begin
      if (man)
      begin
        chip_out(v[i], div / 2);
        chip_out(!v[i], div / 2);
      end
      else
        chip_out(v[i], div);
    end
  endtask : byte_out

  task automatic send(input int npre, input logic [31:0] sw, input int nsync,
                      input logic [7:0] pl[$], input bit bad, input int div, input bit man);
    // Start half a chip late so the receiver samples mid-chip
    repeat ((man ? div / 2 : div) / 2) @(negedge clk);
    for (int i = 0; i < npre; i++)
      byte_out(8'h55, div, man);
    for (int s = nsync - 1; s >= 0; s--)
      byte_out(sw[8*s +: 8], div, man);
    crc = 16'hffff;
    foreach (pl[i])
    begin
      byte_out(pl[i], div, man);
      for (int b = 7; b >= 0; b--)
        crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ pl[i][b]) ? 16'h8005 : 16'h0000);
    end
    if (bad)
      crc = crc ^ 16'h0001;
    byte_out(crc[15:8], div, man);
    byte_out(crc[7:0], div, man);
    rx_line = !rx_line;
  endtask : send
endmodule : rph_tx_model

// ===== testbench/tb_rx_packet_handler.sv
// Purpose: Self-checking bench for the receive packet handler
// Assumes: Inputs driven on the falling edge, seed 62858
// Notes: Expected bytes and events wait in queues for the monitor
`timescale 1ns/100ps

module tb_rx_packet_handler;
  import rph_pkg::*;
  logic clk = 1'b0, rst = 1'b1, rx_enable = 1'b0, ook_mode = 1'b0;
  logic skip_preamble = 1'b0, manchester_en = 1'b0, crc_en = 1'b1, rx_ready = 1'b1;
  logic [15:0] rate_div = 16'h0028;
  logic [15:0] seed = 16'hf58a;
  logic [7:0] preamble_len = 8'h00, payload_len = 8'h06, rx_data;
  logic [1:0] sync_len = 2'h0;
  logic [31:0] sync_word = 32'h0;
  logic rx_line, rx_valid, pkt_valid, pkt_error, sync_found, rate_error, busy, stall = 1'b0;
  logic [7:0] exp_data[$];
  logic [1:0] exp_evt[$];
  int checks = 0, failures = 0, cycles = 0, syncs = 0;
  logic sync_d = 1'b0;

  always #25 clk = ~clk;

  rph_rx_packet_handler u_rph_rx_packet_handler (.clk(clk), .rst(rst), .rx_line(rx_line),
    .rx_enable(rx_enable), .rate_div(rate_div), .ook_mode(ook_mode),
    .preamble_len(preamble_len), .skip_preamble(skip_preamble), .sync_len(sync_len),
    .sync_word(sync_word), .manchester_en(manchester_en), .crc_en(crc_en),
    .payload_len(payload_len), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .pkt_valid(pkt_valid), .pkt_error(pkt_error), .sync_found(sync_found),
    .rate_error(rate_error), .busy(busy));

  rph_tx_model u_rph_tx_model (.clk(clk), .rx_line(rx_line));

  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 7);
    seed = seed ^ (seed >> 9);
    seed = seed ^ (seed << 8);
    return seed;
  endfunction : rnd

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  // ********************
  // Drivers and monitor
  // ********************
  task automatic run_pkt(input int npre, input logic [31:0] sw, input int nsync, input int n,
                         input int keep, input bit bad, input bit man);
    logic [7:0] pl[$];
    pl = {};
    for (int i = 0; i < n; i++)
    begin
      pl.push_back(8'(rnd()));
      if (i < keep)
        exp_data.push_back(pl[i]);
    end
    // Without CRC checking every packet ends as valid
    exp_evt.push_back((crc_en && (bad || keep < n)) ? 2'b01 : 2'b10);
    payload_len = 8'(n);
    manchester_en = man;
    check(busy, 1'b0);
    rx_enable = 1'b1;
    u_rph_tx_model.send(npre, sw, nsync, pl, bad, rate_div, man);
    repeat (200) @(negedge clk);
    rx_enable = 1'b0;
    @(negedge clk);
  endtask : run_pkt

  // Random host back-pressure; rx_ready held low while stall is set
  always @(negedge clk)
    rx_ready <= stall ? 1'b0 : (rnd() % 4 != 0);

  always @(posedge clk)
  begin
    cycles++;
    if (!rst && rx_valid === 1'b1 && rx_ready)
      check(rx_data, exp_data.size() ? exp_data.pop_front() : 8'hxx);
    if (!rst && (pkt_valid !== 1'b0 || pkt_error !== 1'b0))
      check({pkt_valid, pkt_error}, exp_evt.size() ? exp_evt.pop_front() : 2'bxx);
    if (sync_d)
      check(busy, 1'b1);
    sync_d <= (sync_found === 1'b1);
    if (sync_found === 1'b1)
      syncs++;
    if (cycles == 60000)
    begin
      failures++;
      finish_test();
    end
  end

  // ********************
  // Scenarios
  // ********************
  initial
  begin
    logic [15:0] rd[5];
    logic om[5];
    logic re[5];
    rd = '{DIV_FSK_MIN - 16'h0001, DIV_FSK_MIN, DIV_OOK_MIN - 16'h0001, DIV_OOK_MIN,
           DIV_OOK_MAX + 16'h0001};
    om = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    re = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    repeat (3) @(negedge clk);
    rst = 1'b0;
    foreach (rd[i])
    begin
      ook_mode = om[i];
      rate_div = rd[i];
      repeat (3) @(negedge clk);
      check(rate_error, re[i]);
    end
    ook_mode = 1'b0;
    rate_div = DIV_FSK_MIN;
    repeat (3) @(negedge clk);
    run_pkt(4, 32'h2dd4, 2, 6, 6, 1'b0, 1'b0);
    run_pkt(4, 32'h2dd4, 2, 6, 6, 1'b1, 1'b0);
    preamble_len = PRE_MIN;
    sync_len = 2'h2;
    sync_word = {8'h00, rnd(), 8'h81};
    run_pkt(3, sync_word, 3, 5, 5, 1'b0, 1'b1);
    preamble_len = 8'hff;
    skip_preamble = 1'b1;
    sync_word = 32'h0;
    run_pkt(1, 32'h2dd4, 2, 6, 6, 1'b0, 1'b0);
    skip_preamble = 1'b0;
    preamble_len = 8'h00;
    // Corrupt CRC must still give a valid packet when checking is off
    crc_en = 1'b0;
    run_pkt(4, 32'h2dd4, 2, 4, 4, 1'b1, 1'b0);
    crc_en = 1'b1;
    stall = 1'b1;
    // Head plus 16 stored words; the last byte is lost
    run_pkt(4, 32'h2dd4, 2, 18, FIFO_D + 1, 1'b0, 1'b0);
    stall = 1'b0;
    repeat (400) @(negedge clk);
    check(exp_data.size(), 0);
    check(exp_evt.size(), 0);
    check(syncs, 6);
    finish_test();
  end
endmodule : tb_rx_packet_handler
